// >>> common/osc_regs.svh
`ifndef OSC_REGS_SVH
`define OSC_REGS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define OSC_REF_LOW_ADDR 8'h12
`define OSC_CTRL_ADDR 8'h87
`define OSC_LOOP_ADDR 8'h89

// ****************************************************************
// field positions
// ****************************************************************
`define OSC_CTRL_RST_BIT 7
`define OSC_CTRL_NEWF_BIT 6
`define OSC_CTRL_HOLDM_BIT 5
`define OSC_CTRL_HOLDVC_BIT 4
`define OSC_CTRL_RECALL_BIT 0
`define OSC_LOOP_HOLD_BIT 4

// ****************************************************************
// reset values
// ****************************************************************
`define OSC_REF_LOW_RESET 8'h00
`define OSC_CTRL_RESET 8'h00
`define OSC_LOOP_RESET 8'h00

// ****************************************************************
// timing
// ****************************************************************
`define OSC_MCLK_KHZ 40000
`define OSC_SOFT_RST_NS 1000
`define OSC_RECALL_NS 2000
`define OSC_SOFT_RST_CYC ((`OSC_SOFT_RST_NS * `OSC_MCLK_KHZ + 999999) / 1000000)
`define OSC_RECALL_CYC ((`OSC_RECALL_NS * `OSC_MCLK_KHZ + 999999) / 1000000)
`define OSC_TMR_W 8

`endif

// >>> common/osc_pkg.sv
`include "osc_regs.svh"

package osc_pkg;

    typedef enum logic [3:0] {
        I2C_IDLE,
        I2C_ADDR,
        I2C_ACK_A,
        I2C_REG,
        I2C_ACK_R,
        I2C_WDATA,
        I2C_ACK_W,
        I2C_RDATA,
        I2C_MACK
    } i2c_state_t;

    typedef struct packed {
        i2c_state_t st;
        logic [7:0] sh;
        logic [7:0] ptr;
        logic [3:0] cnt;
        logic rw;
        logic nack;
        logic sda_oe;
        logic sda_o;
        logic wr_stb;
        logic scl_s1;
        logic scl_s2;
        logic scl_s3;
        logic sda_s1;
        logic sda_s2;
        logic sda_s3;
    } i2c_st_t;

    typedef struct packed {
        logic [7:0] ref_low;
        logic [7:0] dco_word;
        logic soft_rst;
        logic new_freq;
        logic nf_pulse;
        logic hold_m;
        logic hold_vc;
        logic recall;
        logic hold_loop;
        logic clk_en;
        logic [`OSC_TMR_W-1:0] tmr;
    } bank_st_t;

endpackage

// >>> common/reg_access_if.sv
`timescale 1ns/1ps

interface reg_access_if;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr_stb;
    logic [7:0] rdata;
    logic abort;

    modport target (output addr, output wdata, output wr_stb, input rdata, input abort);
    modport bank (input addr, input wdata, input wr_stb, output rdata, output abort);
endinterface

// >>> core/i2c_target.sv
`timescale 1ns/1ps

module i2c_target #(
    parameter logic [6:0] DEV_ADDR = 7'h55  // arbitrary value
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // serial pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // register side
    reg_access_if.target bus
);
    import osc_pkg::*;

    i2c_st_t q;
    i2c_st_t d;
    logic rise;
    logic fall;
    logic start;
    logic stop;

    assign sda_o = q.sda_o;
    assign sda_oe = q.sda_oe;
    assign bus.addr = q.ptr;
    assign bus.wdata = q.sh;
    assign bus.wr_stb = q.wr_stb;

    always_comb begin
        rise = q.scl_s2 && !q.scl_s3;
        fall = !q.scl_s2 && q.scl_s3;
        start = q.scl_s2 && q.scl_s3 && q.sda_s3 && !q.sda_s2;
        stop = q.scl_s2 && q.scl_s3 && !q.sda_s3 && q.sda_s2;
        d = q;
        d.wr_stb = 1'b0;
        d.sda_o = 1'b0;
        d.scl_s1 = scl_i;
        d.scl_s2 = q.scl_s1;
        d.scl_s3 = q.scl_s2;
        d.sda_s1 = sda_i;
        d.sda_s2 = q.sda_s1;
        d.sda_s3 = q.sda_s2;
        if (bus.abort) begin
            d.st = I2C_IDLE;
            d.sda_oe = 1'b0;
        end else if (start) begin
            d.st = I2C_ADDR;
            d.cnt = 4'h0;
            d.sda_oe = 1'b0;
        end else if (stop) begin
            d.st = I2C_IDLE;
            d.sda_oe = 1'b0;
        end else if (rise) begin
            if (q.st == I2C_ADDR || q.st == I2C_REG || q.st == I2C_WDATA) begin
                d.sh = {q.sh[6:0], q.sda_s2};
                d.cnt = q.cnt + 4'h1;
            end else if (q.st == I2C_MACK) begin
                d.nack = q.sda_s2;
            end
        end else if (fall) begin
            unique case (q.st)
                I2C_IDLE: begin
                    d.sda_oe = 1'b0;
                end
                I2C_ADDR: begin
                    if (q.cnt == 4'h8) begin
                        if (q.sh[7:1] == DEV_ADDR) begin
                            d.sda_oe = 1'b1;
                            d.rw = q.sh[0];
                            d.st = I2C_ACK_A;
                        end else begin
                            d.st = I2C_IDLE;
                        end
                    end
                end
                I2C_ACK_A, I2C_MACK: begin
                    // the byte is fetched at the falling edge, so reads see the latest value
                    if ((q.st == I2C_ACK_A && q.rw) || (q.st == I2C_MACK && !q.nack)) begin
                        d.sh = bus.rdata;
                        d.sda_oe = ~bus.rdata[7];
                        d.cnt = 4'h1;
                        d.ptr = q.ptr + 8'h01;
                        d.st = I2C_RDATA;
                    end else begin
                        d.sda_oe = 1'b0;
                        d.cnt = 4'h0;
                        d.st = (q.st == I2C_ACK_A) ? I2C_REG : I2C_IDLE;
                    end
                end
                I2C_REG, I2C_WDATA: begin
                    if (q.cnt == 4'h8) begin
                        if (q.st == I2C_REG) begin
                            d.ptr = q.sh;
                            d.st = I2C_ACK_R;
                        end else begin
                            d.wr_stb = 1'b1;
                            d.st = I2C_ACK_W;
                        end
                        d.sda_oe = 1'b1;
                    end
                end
                I2C_ACK_R, I2C_ACK_W: begin
                    if (q.st == I2C_ACK_W) begin
                        d.ptr = q.ptr + 8'h01;
                    end
                    d.sda_oe = 1'b0;
                    d.cnt = 4'h0;
                    d.st = I2C_WDATA;
                end
                I2C_RDATA: begin
                    if (q.cnt == 4'h8) begin
                        d.sda_oe = 1'b0;
                        d.st = I2C_MACK;
                    end else begin
                        d.sda_oe = ~q.sh[6];
                        d.sh = {q.sh[6:0], 1'b0};
                        d.cnt = q.cnt + 4'h1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            q <= '{st: I2C_IDLE, scl_s1: 1'b1, scl_s2: 1'b1, scl_s3: 1'b1,
                   sda_s1: 1'b1, sda_s2: 1'b1, sda_s3: 1'b1, default: '0};
        end else begin
            q <= d;
        end
    end
endmodule

// >>> core/osc_freq_control_regs.sv
`timescale 1ns/1ps


module osc_freq_control_regs #(
    parameter logic [6:0] DEV_ADDR = 7'h55,     // arbitrary value
    parameter logic [7:0] NVM_REF_LOW = 8'h00
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // serial pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // synthesis loop side
    input wire logic freq_applied,
    output logic [7:0] ref_freq_word,
    output logic new_freq_strobe,
    output logic hold_vc_converter_word,
    output logic hold_synth_loop,
    output logic clk_out_en
);
    import osc_pkg::*;

    // ****************************************************************
    // timer loads and reset bytes
    // ****************************************************************
    // both timers count down to zero, so the load is one less than the span
    localparam logic [`OSC_TMR_W-1:0] SOFT_LOAD = `OSC_TMR_W'(`OSC_SOFT_RST_CYC - 1);
    localparam logic [`OSC_TMR_W-1:0] RECALL_LOAD = `OSC_TMR_W'(`OSC_RECALL_CYC - 1);
    localparam logic [7:0] REF_RST_VAL = `OSC_REF_LOW_RESET;
    localparam logic [7:0] CTRL_RST_VAL = `OSC_CTRL_RESET;
    localparam logic [7:0] LOOP_RST_VAL = `OSC_LOOP_RESET;

    reg_access_if bus ();

    bank_st_t q;
    bank_st_t d;
    bank_st_t rst_val;
    logic [7:0] rd;
    logic [7:0] ctrl_rd;
    logic [7:0] loop_rd;

    // ****************************************************************
    // serial port
    // ****************************************************************
    i2c_target #(
        .DEV_ADDR(DEV_ADDR)
    ) u_i2c (
        .mclk(mclk),
        .rst_n(rst_n),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .sda_o(sda_o),
        .sda_oe(sda_oe),
        .bus(bus)
    );

    // ****************************************************************
    // bank side of the register bus
    // ****************************************************************
    assign bus.abort = q.soft_rst;
    assign bus.rdata = rd;

    // ****************************************************************
    // outputs, all straight from the bank flops
    // ****************************************************************
    assign ref_freq_word = q.dco_word;
    assign new_freq_strobe = q.nf_pulse;
    assign hold_vc_converter_word = q.hold_vc;
    assign hold_synth_loop = q.hold_loop;
    assign clk_out_en = q.clk_en;

    // ****************************************************************
    // read-back images
    // ****************************************************************
    // bits 3:1 of the control byte and the reserved loop bits always read zero
    always_comb begin
        ctrl_rd = 8'h00;
        ctrl_rd[`OSC_CTRL_RST_BIT] = q.soft_rst;
        ctrl_rd[`OSC_CTRL_NEWF_BIT] = q.new_freq;
        ctrl_rd[`OSC_CTRL_HOLDM_BIT] = q.hold_m;
        ctrl_rd[`OSC_CTRL_HOLDVC_BIT] = q.hold_vc;
        ctrl_rd[`OSC_CTRL_RECALL_BIT] = q.recall;
        loop_rd = 8'h00;
        loop_rd[`OSC_LOOP_HOLD_BIT] = q.hold_loop;
    end

    // ****************************************************************
    // read mux
    // ****************************************************************
    // unmapped offsets read zero so a stray pointer cannot leak state
    always_comb begin
        rd = 8'h00;
        unique case (bus.addr)
            `OSC_REF_LOW_ADDR: rd = q.ref_low;
            `OSC_CTRL_ADDR: rd = ctrl_rd;
            `OSC_LOOP_ADDR: rd = loop_rd;
            default: rd = 8'h00;
        endcase
    end

    // ****************************************************************
    // state left behind by a soft reset
    // ****************************************************************
    // the undefined middle control bits come back as zero; the low reference
    // byte is refilled from the stored default rather than the power-up value,
    // so a soft reset lands where a recall would
    always_comb begin
        rst_val = '0;
        rst_val.ref_low = NVM_REF_LOW;
        rst_val.dco_word = NVM_REF_LOW;
        rst_val.soft_rst = CTRL_RST_VAL[`OSC_CTRL_RST_BIT];
        rst_val.new_freq = CTRL_RST_VAL[`OSC_CTRL_NEWF_BIT];
        rst_val.recall = CTRL_RST_VAL[`OSC_CTRL_RECALL_BIT];
        rst_val.hold_loop = LOOP_RST_VAL[`OSC_LOOP_HOLD_BIT];
        rst_val.clk_en = 1'b1;
    end

    // ****************************************************************
    // register bank and sequencing
    // ****************************************************************
    always_comb begin
        d = q;
        d.nf_pulse = 1'b0;

        if (q.soft_rst) begin
            d.clk_en = 1'b0;
            if (q.tmr == '0) begin
                // everything returns to defaults, including the self-clearing bit
                d = rst_val;
                d.ref_low = NVM_REF_LOW;
                d.dco_word = NVM_REF_LOW;
            end else begin
                d.tmr = q.tmr - `OSC_TMR_W'(1);
            end
        end else begin
            // recall only reloads the low reference byte; the serial engine keeps its pointer and state
            if (q.recall) begin
                if (q.tmr == '0) begin
                    d.ref_low = NVM_REF_LOW;
                    d.recall = 1'b0;
                end else begin
                    d.tmr = q.tmr - `OSC_TMR_W'(1);
                end
            end

            // applied report clears the flag, but a fresh request in the same cycle wins
            if (freq_applied) begin
                d.new_freq = 1'b0;
            end

            // bits 3:1 of the control byte have no storage, so writes to them vanish
            if (bus.wr_stb) begin
                unique case (bus.addr)
                    `OSC_REF_LOW_ADDR: d.ref_low = bus.wdata;
                    `OSC_CTRL_ADDR: begin
                        d.hold_m = bus.wdata[`OSC_CTRL_HOLDM_BIT];
                        d.hold_vc = bus.wdata[`OSC_CTRL_HOLDVC_BIT];
                        if (bus.wdata[`OSC_CTRL_NEWF_BIT]) begin
                            d.new_freq = 1'b1;
                            d.nf_pulse = 1'b1;
                        end
                        if (bus.wdata[`OSC_CTRL_RECALL_BIT] && !q.recall) begin
                            d.recall = 1'b1;
                            d.tmr = RECALL_LOAD;
                        end
                        if (bus.wdata[`OSC_CTRL_RST_BIT]) begin
                            // takes over any recall in flight and every other bit of the
                            // byte, so no strobe escapes while the output is tristated
                            d.hold_m = q.hold_m;
                            d.hold_vc = q.hold_vc;
                            d.new_freq = q.new_freq && !freq_applied;
                            d.nf_pulse = 1'b0;
                            d.soft_rst = 1'b1;
                            d.recall = 1'b0;
                            d.clk_en = 1'b0;
                            d.tmr = SOFT_LOAD;
                        end
                    end
                    `OSC_LOOP_ADDR: d.hold_loop = bus.wdata[`OSC_LOOP_HOLD_BIT];
                    default: d.hold_loop = q.hold_loop;
                endcase
            end

            // frozen word avoids interim steps while bytes are rewritten one at a time
            if (!q.hold_m) begin
                d.dco_word = q.ref_low;
            end
        end
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            // synchronous reset; a soft reset takes its own path through the sequencer
            q <= '{ref_low: REF_RST_VAL, dco_word: REF_RST_VAL,
                   clk_en: 1'b1, default: '0};
        end else begin
            q <= d;
        end
    end
endmodule

// >>> verification/osc_freq_control_regs_props.sv
`timescale 1ns/1ps

module osc_freq_control_regs_props (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // watched pins
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic freq_applied,
    input wire logic [7:0] ref_freq_word,
    input wire logic new_freq_strobe,
    input wire logic hold_vc_converter_word,
    input wire logic hold_synth_loop,
    input wire logic clk_out_en
);
    logic [7:0] lo_cnt_q;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // ********************
    // tristate spell length
    // ********************
    always_ff @(posedge mclk) begin
        if (!rst_n || clk_out_en) begin
            lo_cnt_q <= 8'h00;
        end else begin
            lo_cnt_q <= lo_cnt_q + 8'h01;
        end
    end
    // ********************
    // properties
    // ********************
    a_strobe_one_cycle: assert property (new_freq_strobe |=> !new_freq_strobe)
        else $error("new freq strobe longer than one cycle");
    a_reset_values: assert property ($rose(rst_n) |-> clk_out_en && !sda_oe
        && !new_freq_strobe && ref_freq_word == 8'h00 && !hold_synth_loop
        && !hold_vc_converter_word) else $error("outputs wrong after reset");
    a_tristate_span: assert property ($rose(clk_out_en) |-> lo_cnt_q inside {[40:42]})
        else $error("tristate spell has wrong length");
    a_reset_bounded: assert property (lo_cnt_q <= 8'h2a)
        else $error("soft reset does not end");
    a_released_in_reset: assert property ((!clk_out_en && !$past(clk_out_en, 2))
        |-> !sda_oe) else $error("data line held during soft reset");
    a_reset_no_strobe: assert property (new_freq_strobe |-> clk_out_en)
        else $error("strobe during soft reset");
    a_holds_cleared: assert property ($rose(clk_out_en)
        |-> ##[0:2] (!hold_synth_loop && !hold_vc_converter_word))
        else $error("holds survive soft reset");
    a_ack_scl_low: assert property ($rose(sda_oe) |-> !scl_i)
        else $error("data line pulled while clock high");
    cover property (new_freq_strobe);
    cover property ($fell(clk_out_en));
    cover property ($rose(sda_oe));
endmodule

bind osc_freq_control_regs osc_freq_control_regs_props osc_freq_control_regs_props_inst (
    .mclk, .rst_n, .scl_i, .sda_i, .sda_o, .sda_oe, .freq_applied, .ref_freq_word,
    .new_freq_strobe, .hold_vc_converter_word, .hold_synth_loop, .clk_out_en
);

// >>> verification/i2c_master_model.sv
`timescale 1ns/1ps

module i2c_master_model #(
    parameter logic [6:0] DEV = 7'h55
) (
    // clock and line
    input wire logic mclk,
    input wire logic sda,
    // driven pins
    output logic scl,
    output logic pull
);
    logic ack;
    logic [6:0] dev = DEV;
    initial begin
        scl = 1'b1;
        pull = 1'b0;
    end
    task automatic w(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // sampled on the falling edge so the answer flops have settled
    task automatic bitx(input logic b, output logic r);
        pull <= !b;
        w(4);
        scl <= 1'b1;
        w(8);
        @(negedge mclk);
        r = sda;
        @(posedge mclk);
        scl <= 1'b0;
        w(4);
    endtask
    task automatic bytex(input logic [7:0] d, input logic b9, output logic [7:0] r);
        for (int i = 7; i >= 0; i--) bitx(d[i], r[i]);
        bitx(b9, ack);
    endtask
    task automatic start();
        // every request opens on a rising edge, whatever the caller waited on
        @(posedge mclk);
        pull <= 1'b0;
        w(4);
        scl <= 1'b1;
        w(6);
        pull <= 1'b1;
        w(6);
        scl <= 1'b0;
        w(4);
    endtask
    task automatic stop();
        pull <= 1'b1;
        w(4);
        scl <= 1'b1;
        w(6);
        pull <= 1'b0;
        w(10);
    endtask
    // ok falls if any byte goes unacknowledged, e.g. after an aborting soft reset
    task automatic wr(input logic [7:0] a, input logic [7:0] q[$], output logic ok);
        logic [7:0] r;
        start();
        bytex({dev, 1'b0}, 1'b1, r);
        ok = !ack;
        bytex(a, 1'b1, r);
        ok &= !ack;
        foreach (q[i]) begin
            bytex(q[i], 1'b1, r);
            ok &= !ack;
        end
        stop();
    endtask
    // single byte read, closed by a refusal bit
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        logic [7:0] r;
        start();
        bytex({dev, 1'b0}, 1'b1, r);
        ok = !ack;
        bytex(a, 1'b1, r);
        start();
        bytex({dev, 1'b1}, 1'b1, r);
        bytex(8'hff, 1'b1, d);
        stop();
    endtask
endmodule

// >>> verification/tb_osc_freq_control_regs.sv
`timescale 1ns/1ps

module tb_osc_freq_control_regs;
    import osc_pkg::*;
    localparam logic [7:0] NVM = 8'h3c;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic freq_applied = 1'b0;
    logic scl, pull, sda_o, sda_oe, strobe, hold_vc, hold_loop, clk_out_en, ok;
    logic [7:0] ref_freq_word, d;
    wire logic sda = !((sda_oe && !sda_o) || pull);
    int num_errors = 0;
    int cmp_count = 0;
    int seed = 32'hd9d3;
    int strobes = 0;
    int lo_cnt = 0;
    int exp_ref = 0;
    // bank mirror kept from the rules, never from the design
    int mdl_ref = 0;
    int mdl_word = 0;
    int mdl_hold_m = 0;
    always #12.5 mclk = ~mclk;
    always @(posedge mclk) begin
        strobes += strobe;
        lo_cnt += !clk_out_en;
    end
    osc_freq_control_regs #(.NVM_REF_LOW(NVM)) osc_freq_control_regs_inst (
        .mclk(mclk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe(sda_oe), .freq_applied(freq_applied), .ref_freq_word(ref_freq_word),
        .new_freq_strobe(strobe), .hold_vc_converter_word(hold_vc),
        .hold_synth_loop(hold_loop), .clk_out_en(clk_out_en));
    i2c_master_model i2c_master_model_inst (.mclk(mclk), .sda(sda), .scl(scl), .pull(pull));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        i2c_master_model_inst.wr(a, {v}, ok);
        if (ok && a == 8'h12) begin
            mdl_ref = v;
        end
        if (ok && a == 8'h87) begin
            mdl_hold_m = v[5];
        end
        if (mdl_hold_m == 0) begin
            mdl_word = mdl_ref;
        end
        @(negedge mclk);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        i2c_master_model_inst.rd(a, d, ok);
        check(d, e);
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (80000) @(posedge mclk);
        num_errors++;
        final_report();
    end
    initial begin
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        rd_chk(8'h12, 8'h00);
        rd_chk(8'h87, 8'h00);
        rd_chk(8'h89, 8'h00);
        $display("reset test done");
        repeat (3) begin
            exp_ref = $random(seed) & 8'hff;
            wr(8'h12, exp_ref[7:0]);
            check(ref_freq_word, exp_ref[7:0]);
            rd_chk(8'h12, exp_ref[7:0]);
        end
        wr(8'h87, 8'h20);
        wr(8'h12, 8'ha5);
        check(ref_freq_word, mdl_word[7:0]);
        rd_chk(8'h12, 8'ha5);
        wr(8'h87, 8'h00);
        check(ref_freq_word, mdl_word[7:0]);
        wr(8'h87, 8'h10);
        check({7'h0, hold_vc}, 8'h01);
        rd_chk(8'h87, 8'h10);
        $display("freeze test done");
        // divider bytes sit outside this bank; only the low reference byte moves here
        wr(8'h89, 8'hff);
        check({7'h0, hold_loop}, 8'h01);
        rd_chk(8'h89, 8'h10);
        wr(8'h12, 8'h5a);
        wr(8'h89, 8'h00);
        check({7'h0, hold_loop}, 8'h00);
        wr(8'h87, 8'h40);
        check(strobes[7:0], 8'h01);
        rd_chk(8'h87, 8'h40);
        @(posedge mclk);
        freq_applied <= 1'b1;
        @(posedge mclk);
        freq_applied <= 1'b0;
        rd_chk(8'h87, 8'h00);
        $display("new frequency test done");
        // recall mid transfer, then an unmapped byte and the loop register
        i2c_master_model_inst.wr(8'h87, {8'h01, 8'h00, 8'h10}, ok);
        check({7'h0, ok}, 8'h01);
        rd_chk(8'h89, 8'h10);
        rd_chk(8'h87, 8'h00);
        rd_chk(8'h12, NVM);
        mdl_ref = NVM;
        mdl_hold_m = 0;
        mdl_word = mdl_ref;
        check(ref_freq_word, mdl_word[7:0]);
        wr(8'h89, 8'h00);
        wr(8'h40, 8'h99);
        rd_chk(8'h40, 8'h00);
        i2c_master_model_inst.dev = 7'h2a;
        wr(8'h12, 8'h11);
        check({7'h0, ok}, 8'h00);
        i2c_master_model_inst.dev = 7'h55;
        $display("recall test done");
        wr(8'h12, 8'h5a);
        i2c_master_model_inst.wr(8'h87, {8'hb0, 8'h55}, ok);
        check({7'h0, ok}, 8'h00);
        check({7'h0, lo_cnt inside {[40:42]}}, 8'h01);
        check(strobes[7:0], 8'h01);
        rd_chk(8'h87, 8'h00);
        rd_chk(8'h12, NVM);
        @(negedge mclk);
        check({6'h0, hold_vc, clk_out_en}, 8'h01);
        check(ref_freq_word, NVM);
        $display("soft reset test done");
        final_report();
    end
endmodule
